// ==== cisb_pkg.sv ====
// Constants and types for the CAN ISP boot session block
package cisb_pkg;
  localparam logic [15:0] BOOT_ROM_ADDR    = 16'hf800;
  localparam logic [15:0] APP_ADDR         = 16'h0000;
  localparam logic [7:0]  FLASH_CTRL_HW    = 8'h00;
  localparam logic [7:0]  FLASH_CTRL_SW    = 8'h0f;
  localparam logic [7:0]  SBV_LIMIT        = 8'hf8;
  localparam logic [7:0]  AUTOBAUD_CODE    = 8'hff;
  localparam logic [7:0]  NODE_BROADCAST   = 8'hff;
  localparam logic [7:0]  BASE_MAX         = 8'h7f;
  localparam logic [7:0]  BASE_RESET       = 8'h00;
  localparam logic [7:0]  SESSION_OPEN     = 8'h01;
  localparam logic [7:0]  SESSION_CLOSED   = 8'h00;
  localparam logic [3:0]  SELECT_LEN       = 4'h1;
  localparam logic [3:0]  ANSWER_LEN       = 4'h2;
  localparam logic [3:0]  ERROR_LEN        = 4'h1;
  localparam logic [7:0]  BOOT_VERSION     = 8'h01;
  localparam logic [3:0]  NIB_SELECT       = 4'h0;
  localparam logic [3:0]  NIB_PROG_START   = 4'h1;
  localparam logic [3:0]  NIB_PROG_DATA    = 4'h2;
  localparam logic [3:0]  NIB_DISPLAY      = 4'h3;
  localparam logic [3:0]  NIB_WRITE_CMD    = 4'h4;
  localparam logic [3:0]  NIB_READ_CMD     = 4'h5;
  localparam logic [3:0]  NIB_ERROR        = 4'h6;
  localparam logic [7:0]  BASE_MASK        = 8'h7f;
  localparam logic [7:0]  CFG_DEFAULT      = 8'hff;
  localparam logic [7:0]  SBV_DEFAULT      = 8'hfc;
  localparam logic        FUSE_DEFAULT     = 1'b1;
  // Register port offsets
  localparam logic [3:0]  REG_BASE         = 4'h0;
  localparam logic [3:0]  REG_NODE         = 4'h1;
  localparam logic [3:0]  REG_EXTRA        = 4'h2;
  localparam logic [3:0]  REG_BT1          = 4'h3;
  localparam logic [3:0]  REG_BT2          = 4'h4;
  localparam logic [3:0]  REG_BT3          = 4'h5;
  localparam logic [3:0]  REG_SBV          = 4'h6;
  localparam logic [3:0]  REG_FUSE         = 4'h7;
  localparam logic [3:0]  REG_STATUS       = 4'h8;
  localparam logic [3:0]  REG_ERRSEND      = 4'h9;
  typedef enum logic [1:0] {
    CISB_SRC_APP,
    CISB_SRC_USER_BOOT,
    CISB_SRC_ROM_BOOT
  } cisb_src_t;
  typedef enum logic [1:0] {
    CISB_ST_IDLE,
    CISB_ST_ANSWER,
    CISB_ST_ERROR
  } cisb_state_t;
endpackage

// ==== cisb_core.sv ====
// Boot selection and CAN ISP session layer
`timescale 1ns/1ps
`default_nettype none
module cisb_core (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        external_access_pin,
  input  wire logic        program_store_enable_pin,
  input  wire logic        reset_pin_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic        rx_ide,
  input  wire logic        rx_rtr,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [7:0]  rx_data0,
  input  wire logic        timing_found,
  output logic             rx_ack_enable,
  output logic             tx_valid,
  output logic      [10:0] tx_id,
  output logic      [3:0]  tx_dlc,
  output logic      [7:0]  tx_data0,
  output logic      [7:0]  tx_data1,
  input  wire logic        tx_done,
  output logic             boot_rom_enable_bit,
  output logic      [15:0] start_address,
  output logic      [7:0]  flash_control_reg,
  output logic      [1:0]  boot_source,
  output logic             autobaud_mode,
  output logic      [7:0]  bit_timing_byte_one,
  output logic      [7:0]  bit_timing_byte_two,
  output logic      [7:0]  bit_timing_byte_three,
  output logic             session_open,
  output logic             command_pulse,
  output logic      [3:0]  command_nibble
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] ea_sync;
  logic [1:0] program_store_enable_pin_sync;
  logic [1:0] rst_sync;
  logic       rst_prev;
  always_ff @(posedge clock) begin
    ea_sync   <= {ea_sync[0], external_access_pin};
    program_store_enable_pin_sync <= {program_store_enable_pin_sync[0], program_store_enable_pin};
    rst_sync  <= {rst_sync[0], reset_pin_n};
    rst_prev  <= rst_sync[1];
  end
  wire reset_fall = rst_prev & ~rst_sync[1];
  ////////////////////////////////////////////////////////////////////////////
  // Configuration bytes
  logic [7:0] identifier_base_byte;
  logic [7:0] node_number_byte;
  logic [7:0] extra_config_byte;
  logic [7:0] software_boot_vector;
  logic       boot_jump_fuse;
  logic       hw_condition;
  logic       boot_decided;
  always_ff @(posedge clock) begin
    if (srst) begin
      identifier_base_byte  <= cisb_pkg::BASE_RESET;
      node_number_byte      <= cisb_pkg::CFG_DEFAULT;
      extra_config_byte     <= cisb_pkg::CFG_DEFAULT;
      software_boot_vector  <= cisb_pkg::SBV_DEFAULT;
      boot_jump_fuse        <= cisb_pkg::FUSE_DEFAULT;
      bit_timing_byte_one   <= cisb_pkg::CFG_DEFAULT;
      bit_timing_byte_two   <= cisb_pkg::CFG_DEFAULT;
      bit_timing_byte_three <= cisb_pkg::CFG_DEFAULT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        cisb_pkg::REG_BASE:  identifier_base_byte <= reg_wdata & cisb_pkg::BASE_MASK;
        cisb_pkg::REG_NODE:  node_number_byte <= reg_wdata;
        cisb_pkg::REG_EXTRA: extra_config_byte <= reg_wdata;
        cisb_pkg::REG_BT1:   bit_timing_byte_one <= reg_wdata;
        cisb_pkg::REG_BT2:   bit_timing_byte_two <= reg_wdata;
        cisb_pkg::REG_BT3:   bit_timing_byte_three <= reg_wdata;
        cisb_pkg::REG_SBV:   software_boot_vector <= reg_wdata;
        cisb_pkg::REG_FUSE:  boot_jump_fuse <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Boot source selection, latched on reset pin falling edge
  always_ff @(posedge clock) begin
    if (srst) begin
      hw_condition        <= 1'b0;
      boot_decided        <= 1'b0;
      boot_rom_enable_bit <= 1'b0;
      start_address       <= cisb_pkg::APP_ADDR;
      flash_control_reg   <= cisb_pkg::FLASH_CTRL_HW;
      boot_source         <= cisb_pkg::CISB_SRC_APP;
    end else if (reset_fall) begin
      boot_decided        <= 1'b0;
      hw_condition        <= ea_sync[1] & ~program_store_enable_pin_sync[1];
      boot_rom_enable_bit <= ~boot_jump_fuse;
    end else if (!boot_decided) begin
      boot_decided <= 1'b1;
      if (hw_condition) begin
        boot_rom_enable_bit <= 1'b1;
        start_address       <= cisb_pkg::BOOT_ROM_ADDR;
        flash_control_reg   <= cisb_pkg::FLASH_CTRL_HW;
        boot_source         <= cisb_pkg::CISB_SRC_ROM_BOOT;
      end else if (boot_jump_fuse) begin
        boot_rom_enable_bit <= 1'b0;
        start_address       <= cisb_pkg::APP_ADDR;
        boot_source         <= cisb_pkg::CISB_SRC_APP;
      end else begin
        boot_rom_enable_bit <= 1'b1;
        start_address       <= cisb_pkg::BOOT_ROM_ADDR;
        flash_control_reg   <= cisb_pkg::FLASH_CTRL_SW;
        if (software_boot_vector < cisb_pkg::SBV_LIMIT) begin
          boot_source <= cisb_pkg::CISB_SRC_USER_BOOT;
        end else begin
          boot_source <= cisb_pkg::CISB_SRC_ROM_BOOT;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bit timing source and acknowledge gating
  always_ff @(posedge clock) begin
    if (srst) begin
      autobaud_mode <= 1'b1;
      rx_ack_enable <= 1'b0;
    end else begin
      autobaud_mode <= (extra_config_byte == cisb_pkg::AUTOBAUD_CODE);
      rx_ack_enable <= (extra_config_byte != cisb_pkg::AUTOBAUD_CODE) | timing_found;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Frame decode
  wire frame_ok  = rx_valid & ~rx_ide & ~rx_rtr & rx_ack_enable;
  wire base_hit  = (rx_id[10:4] == identifier_base_byte[6:0]);
  wire is_select = frame_ok & base_hit & (rx_id[3:0] == cisb_pkg::NIB_SELECT)
                   & (rx_dlc == cisb_pkg::SELECT_LEN);
  wire is_cmd    = frame_ok & base_hit & (rx_id[3:0] >= cisb_pkg::NIB_PROG_START)
                   & (rx_id[3:0] <= cisb_pkg::NIB_READ_CMD);
  wire node_hit  = (rx_data0 == cisb_pkg::NODE_BROADCAST) | (rx_data0 == node_number_byte);
  logic          err_req;
  cisb_pkg::cisb_state_t state;
  ////////////////////////////////////////////////////////////////////////////
  // Session state and transmitter
  always_ff @(posedge clock) begin
    if (srst) begin
      state        <= cisb_pkg::CISB_ST_IDLE;
      session_open <= 1'b0;
      tx_valid     <= 1'b0;
      tx_id        <= 11'h000;
      tx_dlc       <= 4'h0;
      tx_data0     <= 8'h00;
      tx_data1     <= 8'h00;
    end else begin
      unique case (state)
        cisb_pkg::CISB_ST_IDLE: begin
          if (is_select && node_hit) begin
            session_open <= ~session_open;
            tx_valid     <= 1'b1;
            tx_id        <= {identifier_base_byte[6:0], cisb_pkg::NIB_SELECT};
            tx_dlc       <= cisb_pkg::ANSWER_LEN;
            tx_data0     <= cisb_pkg::BOOT_VERSION;
            tx_data1     <= session_open ? cisb_pkg::SESSION_CLOSED : cisb_pkg::SESSION_OPEN;
            state        <= cisb_pkg::CISB_ST_ANSWER;
          end else if (err_req && session_open) begin
            tx_valid <= 1'b1;
            tx_id    <= {identifier_base_byte[6:0], cisb_pkg::NIB_ERROR};
            tx_dlc   <= cisb_pkg::ERROR_LEN;
            tx_data0 <= 8'h00;
            tx_data1 <= 8'h00;
            state    <= cisb_pkg::CISB_ST_ERROR;
          end
        end
        cisb_pkg::CISB_ST_ANSWER, cisb_pkg::CISB_ST_ERROR: begin
          if (tx_done) begin
            tx_valid <= 1'b0;
            state    <= cisb_pkg::CISB_ST_IDLE;
          end
        end
        default: state <= cisb_pkg::CISB_ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command hand-off, pulse only while a session is open, nibble captured on any command frame
  always_ff @(posedge clock) begin
    if (srst) begin
      command_pulse  <= 1'b0;
      command_nibble <= 4'h0;
    end else begin
      command_pulse  <= is_cmd & session_open;
      command_nibble <= is_cmd ? rx_id[3:0] : command_nibble;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Error send request, held until the transmitter takes it or the session is closed
  always_ff @(posedge clock) begin
    if (srst) begin
      err_req <= 1'b0;
    end else if (reg_wr && reg_addr == cisb_pkg::REG_ERRSEND) begin
      err_req <= 1'b1;
    end else if (state == cisb_pkg::CISB_ST_ERROR || !session_open) begin
      err_req <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        cisb_pkg::REG_BASE:   reg_rdata <= identifier_base_byte;
        cisb_pkg::REG_NODE:   reg_rdata <= node_number_byte;
        cisb_pkg::REG_EXTRA:  reg_rdata <= extra_config_byte;
        cisb_pkg::REG_BT1:    reg_rdata <= bit_timing_byte_one;
        cisb_pkg::REG_BT2:    reg_rdata <= bit_timing_byte_two;
        cisb_pkg::REG_BT3:    reg_rdata <= bit_timing_byte_three;
        cisb_pkg::REG_SBV:    reg_rdata <= software_boot_vector;
        cisb_pkg::REG_FUSE:   reg_rdata <= {7'h00, boot_jump_fuse};
        cisb_pkg::REG_STATUS: reg_rdata <= {3'h0, boot_source, autobaud_mode, boot_rom_enable_bit, session_open};
        default:              reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_base_limit: assert property (@(posedge clock) disable iff (srst)
    identifier_base_byte <= cisb_pkg::BASE_MAX)
    else $error("base byte above limit");
  a_session_reset: assert property (@(posedge clock)
    srst |=> !session_open && !tx_valid)
    else $error("session not closed after reset");
  a_select_answer: assert property (@(posedge clock) disable iff (srst)
    (state == cisb_pkg::CISB_ST_IDLE && is_select && node_hit)
      |=> tx_valid && tx_dlc == cisb_pkg::ANSWER_LEN && tx_data1 == {7'h00, session_open})
    else $error("select answer wrong");
  a_node_filter: assert property (@(posedge clock) disable iff (srst)
    (is_select && !node_hit) |=> $stable(session_open))
    else $error("foreign node changed session");
  a_closed_ignore: assert property (@(posedge clock) disable iff (srst)
    !session_open |=> !command_pulse)
    else $error("command passed while closed");
  a_ack_gate: assert property (@(posedge clock) disable iff (srst)
    (extra_config_byte == cisb_pkg::AUTOBAUD_CODE && !timing_found) |=> !rx_ack_enable)
    else $error("ack during autobaud");
  a_hw_boot: assert property (@(posedge clock) disable iff (srst)
    (!boot_decided && !reset_fall && hw_condition)
      |=> boot_rom_enable_bit && start_address == cisb_pkg::BOOT_ROM_ADDR
          && flash_control_reg == cisb_pkg::FLASH_CTRL_HW)
    else $error("hardware boot not taken");
  a_fuse_app: assert property (@(posedge clock) disable iff (srst)
    (!boot_decided && !reset_fall && !hw_condition && boot_jump_fuse)
      |=> !boot_rom_enable_bit && start_address == cisb_pkg::APP_ADDR)
    else $error("application start wrong");
  a_sw_boot: assert property (@(posedge clock) disable iff (srst)
    (!boot_decided && !reset_fall && !hw_condition && !boot_jump_fuse)
      |=> boot_rom_enable_bit && start_address == cisb_pkg::BOOT_ROM_ADDR
          && flash_control_reg == cisb_pkg::FLASH_CTRL_SW)
    else $error("software boot path wrong");
  a_user_vector: assert property (@(posedge clock) disable iff (srst)
    (!boot_decided && !reset_fall && !hw_condition && !boot_jump_fuse
      && software_boot_vector < cisb_pkg::SBV_LIMIT) |=> boot_source == cisb_pkg::CISB_SRC_USER_BOOT)
    else $error("user loader not chosen");
  a_stored_timing: assert property (@(posedge clock) disable iff (srst)
    (extra_config_byte != cisb_pkg::AUTOBAUD_CODE) |=> !autobaud_mode)
    else $error("autobaud with stored timing");
  a_cmd_nibble: assert property (@(posedge clock) disable iff (srst)
    (is_cmd && session_open) |=> command_pulse && command_nibble == $past(rx_id[3:0]))
    else $error("command nibble lost");
  a_error_id: assert property (@(posedge clock) disable iff (srst)
    (tx_valid && tx_id[3:0] == cisb_pkg::NIB_ERROR) |-> state == cisb_pkg::CISB_ST_ERROR)
    else $error("error identifier misuse");
  c_open: cover property (@(posedge clock) disable iff (srst) $rose(session_open));
  c_close: cover property (@(posedge clock) disable iff (srst) $fell(session_open));
  c_user_boot: cover property (@(posedge clock) disable iff (srst)
    boot_source == cisb_pkg::CISB_SRC_USER_BOOT);
  c_command: cover property (@(posedge clock) disable iff (srst) command_pulse);
  c_error: cover property (@(posedge clock) disable iff (srst)
    state == cisb_pkg::CISB_ST_ERROR);
endmodule
`default_nettype wire

// ==== cisb_host.sv ====
// Host programming station model on the CAN side of the boot session block
`timescale 1ns/1ps
`default_nettype none
module cisb_host (
  input  wire logic        clock,
  output logic             rx_valid,
  output logic      [10:0] rx_id,
  output logic             rx_ide,
  output logic             rx_rtr,
  output logic      [3:0]  rx_dlc,
  output logic      [7:0]  rx_data0,
  input  wire logic        tx_valid,
  input  wire logic [10:0] tx_id,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [7:0]  tx_data0,
  input  wire logic [7:0]  tx_data1,
  output logic             tx_done
);
  int          lat = 1;
  int          n_tx = 0;
  int          wait_cnt = 0;
  logic [10:0] got_id;
  logic [3:0]  got_dlc;
  logic [7:0]  got_d0;
  logic [7:0]  got_d1;
  logic        remote = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_rtr = 1'b0;
    tx_done = 1'b0;
  end
  // Frame kind and identifier are chosen by the scenario
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [7:0] d0, input logic ide);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_ide <= ide;
    rx_rtr <= remote;
    rx_dlc <= dlc;
    rx_data0 <= d0;
    @(posedge clock);
    rx_valid <= 1'b0;
    // Released lines carry the bitwise inverse of the last value, never the last value
    rx_id <= ~id;
    rx_ide <= ~ide;
    rx_rtr <= ~remote;
    rx_dlc <= ~dlc;
    rx_data0 <= ~d0;
  endtask
  // Accept each answer after lat cycles
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_done === 1'b0) begin
      if (wait_cnt >= lat) begin
        tx_done <= 1'b1;
        n_tx++;
        got_id <= tx_id;
        got_dlc <= tx_dlc;
        got_d0 <= tx_data0;
        got_d1 <= tx_data1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      tx_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== can_isp_boot_session_tb.sv ====
// Testbench for the boot selection and CAN ISP session block
`timescale 1ns/1ps
`default_nettype none
module can_isp_boot_session_tb;
  logic        clock = 1'b0, srst = 1'b1, timing_found = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        external_access_pin = 1'b0, program_store_enable_pin = 1'b1, reset_pin_n = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        rx_valid, rx_ide, rx_rtr, tx_done, rx_ack_enable, tx_valid, boot_rom_enable_bit;
  logic        autobaud_mode, session_open, command_pulse;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  rx_dlc, tx_dlc, command_nibble, last_nib;
  logic [7:0]  rx_data0, tx_data0, tx_data1, reg_rdata, flash_control_reg, rd_val;
  logic [7:0]  bit_timing_byte_one, bit_timing_byte_two, bit_timing_byte_three;
  logic [15:0] start_address;
  logic [1:0]  boot_source;
  int          err_count = 0, compares = 0, cycles = 0, pulses = 0, exp_tx = 0;
  cisb_core dut (.clock, .srst, .external_access_pin, .program_store_enable_pin, .reset_pin_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_dlc, .rx_data0,
    .timing_found, .rx_ack_enable, .tx_valid, .tx_id, .tx_dlc, .tx_data0, .tx_data1, .tx_done,
    .boot_rom_enable_bit, .start_address, .flash_control_reg, .boot_source, .autobaud_mode,
    .bit_timing_byte_one, .bit_timing_byte_two, .bit_timing_byte_three, .session_open, .command_pulse,
    .command_nibble);
  cisb_host host (.clock, .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_dlc, .rx_data0, .tx_valid, .tx_id,
    .tx_dlc, .tx_data0, .tx_data1, .tx_done);
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
    if (command_pulse === 1'b1) begin
      pulses++;
      last_nib = command_nibble;
    end
  end
  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Pins held across the reset falling edge, released while reset is still low
  task boot(input logic ea, input logic ps, input logic en, input logic [1:0] src);
    @(posedge clock);
    external_access_pin <= ea;
    program_store_enable_pin <= ps;
    repeat (6) @(posedge clock);
    reset_pin_n <= 1'b0;
    repeat (10) @(posedge clock);
    external_access_pin <= 1'b0;
    program_store_enable_pin <= 1'b1;
    @(posedge clock);
    reset_pin_n <= 1'b1;
    #1 chk(16'(boot_rom_enable_bit), 16'(en), "boot enable");
    chk(16'(boot_source), 16'(src), "boot source");
  endtask
  task answer(input logic yes, input logic [10:0] id, input logic [7:0] d0, input logic [7:0] d1);
    repeat (12) @(posedge clock);
    if (yes) exp_tx++;
    chk(16'(host.n_tx), 16'(exp_tx), "answer count");
    if (yes) begin
      chk(16'(host.got_id), 16'(id), "answer id");
      chk(16'(host.got_dlc), 16'(id[3:0] == 4'h6 ? 4'h1 : 4'h2), "answer length");
      chk({host.got_d0, host.got_d1}, {d0, d1}, "answer data");
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1 chk(16'(session_open), 16'h0000, "session at reset");
    chk(16'(autobaud_mode), 16'h0001, "autobaud at reset");
    rd(cisb_pkg::REG_BASE);
    chk(16'(rd_val), 16'h0000, "base at reset");
    boot(1'b1, 1'b0, 1'b1, cisb_pkg::CISB_SRC_ROM_BOOT);
    chk(start_address, 16'hf800, "hw start");
    chk(16'(flash_control_reg), 16'h0000, "hw flash ctrl");
    boot(1'b0, 1'b1, 1'b0, cisb_pkg::CISB_SRC_APP);
    chk(start_address, 16'h0000, "app start");
    wr(cisb_pkg::REG_FUSE, 8'h00);
    boot(1'b0, 1'b1, 1'b1, cisb_pkg::CISB_SRC_ROM_BOOT);
    chk(start_address, 16'hf800, "sw start");
    chk(16'(flash_control_reg), 16'h000f, "sw flash ctrl");
    wr(cisb_pkg::REG_SBV, 8'hf7);
    boot(1'b0, 1'b1, 1'b1, cisb_pkg::CISB_SRC_USER_BOOT);
    wr(cisb_pkg::REG_SBV, 8'hf8);
    boot(1'b0, 1'b1, 1'b1, cisb_pkg::CISB_SRC_ROM_BOOT);
    boot(1'b1, 1'b0, 1'b1, cisb_pkg::CISB_SRC_ROM_BOOT);
    chk(16'(flash_control_reg), 16'h0000, "hw clears flash ctrl");
    $display("test boot select done");
    host.send(11'h000, 4'h1, 8'hff, 1'b0);
    answer(1'b0, 11'h000, 8'h00, 8'h00);
    chk(16'(rx_ack_enable), 16'h0000, "ack gated");
    timing_found <= 1'b1;
    host.send(11'h001, 4'h0, 8'h00, 1'b0);
    repeat (4) @(posedge clock);
    chk(16'(pulses), 16'h0000, "closed command");
    chk(16'(rx_ack_enable), 16'h0001, "ack after timing");
    host.send(11'h000, 4'h1, 8'h05, 1'b0);
    answer(1'b0, 11'h000, 8'h00, 8'h00);
    host.remote = 1'b1;
    host.send(11'h000, 4'h1, 8'hff, 1'b0);
    answer(1'b0, 11'h000, 8'h00, 8'h00);
    host.remote = 1'b0;
    host.send(11'h000, 4'h1, 8'hff, 1'b1);
    answer(1'b0, 11'h000, 8'h00, 8'h00);
    host.send(11'h000, 4'h1, 8'hff, 1'b0);
    answer(1'b1, 11'h000, 8'h01, 8'h01);
    chk(16'(session_open), 16'h0001, "session opened");
    rd(cisb_pkg::REG_STATUS);
    chk(16'(rd_val), 16'h0017, "status byte");
    for (int n = 1; n <= 6; n++) begin
      host.send(11'(n), 4'h0, 8'h00, 1'b0);
      repeat (4) @(posedge clock);
      chk(16'(pulses), 16'(n < 6 ? n : 5), "command count");
      chk(16'(last_nib), 16'(n < 6 ? n : 5), "command nibble");
    end
    wr(cisb_pkg::REG_ERRSEND, 8'h00);
    answer(1'b1, 11'h006, 8'h00, 8'h00);
    host.lat = 5;
    host.send(11'h000, 4'h1, 8'hff, 1'b0);
    answer(1'b1, 11'h000, 8'h01, 8'h00);
    $display("test session done");
    wr(cisb_pkg::REG_BASE, 8'hff);
    rd(cisb_pkg::REG_BASE);
    chk(16'(rd_val), 16'h007f, "base limit");
    wr(cisb_pkg::REG_NODE, 8'h05);
    host.send(11'h000, 4'h1, 8'h05, 1'b0);
    answer(1'b0, 11'h000, 8'h00, 8'h00);
    host.send(11'h7f0, 4'h1, 8'h05, 1'b0);
    answer(1'b1, 11'h7f0, 8'h01, 8'h01);
    wr(cisb_pkg::REG_EXTRA, 8'h00);
    wr(cisb_pkg::REG_BT1, 8'h12);
    wr(cisb_pkg::REG_BT2, 8'h34);
    wr(cisb_pkg::REG_BT3, 8'h56);
    boot(1'b0, 1'b1, 1'b1, cisb_pkg::CISB_SRC_ROM_BOOT);
    chk(16'(autobaud_mode), 16'h0000, "stored timing");
    chk(16'(bit_timing_byte_one), 16'h0012, "timing byte");
    chk(16'(bit_timing_byte_two), 16'h0034, "timing byte two");
    chk(16'(bit_timing_byte_three), 16'h0056, "timing byte three");
    $display("test relocate and timing done");
    print_verdict();
  end
endmodule
`default_nettype wire
